// ==== src/clock_gen_control_regs.sv ====
// two-wire serial slave and control register bank of the clock synthesizer
// assumes scl and sda are already synchronous to clk_in; sda is open drain
`timescale 1ns/100ps
module clock_gen_control_regs (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  input wire logic host_clock_stop_n_in,
  input wire logic [7:0] loop_one_m_value_in,
  input wire logic [7:0] loop_one_n_value_in,
  input wire logic [5:0] loop_two_m_value_in,
  input wire logic [1:0] loop_two_n_value_in,
  output logic loop_one_enable_out,
  output logic loop_two_enable_out,
  output logic loop_three_enable_out,
  output logic host_divider_enable_out,
  output logic link_divider_enable_out,
  output logic panel_divider_enable_out,
  output logic display96_divider_enable_out,
  output logic loop_one_spread_enable_out,
  output logic loop_three_spread_enable_out,
  output logic [2:0] loop_three_spread_profile_out,
  output logic host_out0_enable_out,
  output logic host_out1_enable_out,
  output logic host_out2_enable_out,
  output logic link_out0_enable_out,
  output logic link_out1_enable_out,
  output logic link_out2_enable_out,
  output logic display_96m_clock_enable_out,
  output logic panel_video_clock_enable_out,
  output logic reference_enable_out,
  output logic reference_slew_select_out,
  output logic host_out0_stoppable_out,
  output logic host_out1_stoppable_out,
  output logic host_out2_stoppable_out,
  output logic [2:0] host_out_running_out
);

  clock_gen_pkg::link_state_t state_r;
  logic scl_q_r;
  logic sda_q_r;
  logic [7:0] shift_r;
  logic [3:0] bitcnt_r;
  logic [1:0] kind_r;
  logic [6:0] ptr_r;
  logic read_r;
  logic count_due_r;
  logic oe_n_r;
  logic [2:0] running_r;
  logic [7:0] rd_data;
  logic [7:0] loop_div;
  logic [7:0] spread;
  logic [7:0] out_en;
  logic [7:0] ref_stop;

  // pins are synchronous already, so one previous sample is enough for edges
  wire scl_rise = scl_in && !scl_q_r;
  wire scl_fall = !scl_in && scl_q_r;
  wire start_seen = scl_in && scl_q_r && sda_q_r && !sda_in;
  wire stop_seen = scl_in && scl_q_r && !sda_q_r && sda_in;
  wire byte_done = (state_r == clock_gen_pkg::ST_RX) && scl_fall && (bitcnt_r == clock_gen_pkg::BITS_PER_BYTE);
  wire addr_match = (shift_r[7:1] == clock_gen_pkg::DEV_ADDR[7:1]);
  wire cmd_single = shift_r[clock_gen_pkg::CMD_SINGLE_BIT];
  wire wr_en = byte_done && (kind_r == clock_gen_pkg::KIND_DATA) && !read_r;
  // a block read answers with its byte count before register data
  wire [7:0] tx_byte = count_due_r ? clock_gen_pkg::BLOCK_BYTE_COUNT : rd_data;

  ctrl_byte_file u_bytes (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .wr_en_in(wr_en),
    .idx_in(ptr_r),
    .wr_data_in(shift_r),
    .loop_one_m_value_in(loop_one_m_value_in),
    .loop_one_n_value_in(loop_one_n_value_in),
    .loop_two_m_value_in(loop_two_m_value_in),
    .loop_two_n_value_in(loop_two_n_value_in),
    .rd_data_out(rd_data),
    .loop_div_out(loop_div),
    .spread_out(spread),
    .out_en_out(out_en),
    .ref_stop_out(ref_stop)
  );

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_r <= clock_gen_pkg::ST_IDLE;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      shift_r <= 8'h00;
      bitcnt_r <= 4'h0;
      kind_r <= clock_gen_pkg::KIND_ADDR;
      ptr_r <= 7'h00;
      read_r <= 1'b0;
      count_due_r <= 1'b0;
      oe_n_r <= 1'b1;
    end
    else
    begin
      scl_q_r <= scl_in;
      sda_q_r <= sda_in;
      if (stop_seen)
      begin
        state_r <= clock_gen_pkg::ST_IDLE;
        oe_n_r <= 1'b1;
      end
      else if (start_seen)
      begin
        // repeated start keeps the pointer set by the command byte
        state_r <= clock_gen_pkg::ST_RX;
        kind_r <= clock_gen_pkg::KIND_ADDR;
        bitcnt_r <= 4'h0;
        oe_n_r <= 1'b1;
      end
      else
      begin
        unique case (state_r)
          clock_gen_pkg::ST_IDLE:
          begin
            oe_n_r <= 1'b1;
          end
          clock_gen_pkg::ST_RX:
          begin
            if (scl_rise)
            begin
              shift_r <= {shift_r[6:0], sda_in};
              bitcnt_r <= bitcnt_r + 4'h1;
            end
            else if (byte_done)
            begin
              if (kind_r == clock_gen_pkg::KIND_ADDR && !addr_match)
                state_r <= clock_gen_pkg::ST_IDLE;
              else
              begin
                state_r <= clock_gen_pkg::ST_ACK;
                oe_n_r <= 1'b0;
              end
              unique case (kind_r)
                clock_gen_pkg::KIND_ADDR:
                begin
                  read_r <= shift_r[0];
                  // only a block command arms the count byte, so a byte read of index 0 gets data
                  count_due_r <= shift_r[0] && count_due_r;
                  kind_r <= clock_gen_pkg::KIND_CMD;
                end
                clock_gen_pkg::KIND_CMD:
                begin
                  ptr_r <= cmd_single ? shift_r[6:0] : 7'h00;
                  kind_r <= cmd_single ? clock_gen_pkg::KIND_DATA : clock_gen_pkg::KIND_COUNT;
                  count_due_r <= !cmd_single;
                end
                clock_gen_pkg::KIND_COUNT:
                begin
                  kind_r <= clock_gen_pkg::KIND_DATA;
                end
                clock_gen_pkg::KIND_DATA:
                begin
                  ptr_r <= ptr_r + 7'h01;
                end
              endcase
            end
          end
          clock_gen_pkg::ST_ACK, clock_gen_pkg::ST_RACK:
          begin
            if (state_r == clock_gen_pkg::ST_RACK && scl_rise && sda_in)
              state_r <= clock_gen_pkg::ST_IDLE;
            else if (scl_fall)
            begin
              bitcnt_r <= 4'h0;
              if (read_r)
              begin
                state_r <= clock_gen_pkg::ST_TX;
                shift_r <= tx_byte;
                oe_n_r <= tx_byte[7];
                count_due_r <= 1'b0;
                if (!count_due_r)
                  ptr_r <= ptr_r + 7'h01;
              end
              else
              begin
                state_r <= clock_gen_pkg::ST_RX;
                oe_n_r <= 1'b1;
              end
            end
          end
          clock_gen_pkg::ST_TX:
          begin
            if (scl_fall)
            begin
              if (bitcnt_r == clock_gen_pkg::LAST_TX_BIT)
              begin
                state_r <= clock_gen_pkg::ST_RACK;
                oe_n_r <= 1'b1;
              end
              else
              begin
                shift_r <= {shift_r[6:0], 1'b0};
                oe_n_r <= shift_r[6];
                bitcnt_r <= bitcnt_r + 4'h1;
              end
            end
          end
          default:
          begin
            state_r <= clock_gen_pkg::ST_IDLE;
            oe_n_r <= 1'b1;
          end
        endcase
      end
    end
  end

  // a stoppable host output halts while the stop input is low
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      running_r <= 3'h7;
    else
    begin
      running_r[0] <= out_en[clock_gen_pkg::BIT_HOST0_EN] &&
                      !(ref_stop[clock_gen_pkg::BIT_HOST0_STOPPABLE] && !host_clock_stop_n_in);
      running_r[1] <= out_en[clock_gen_pkg::BIT_HOST1_EN] &&
                      !(ref_stop[clock_gen_pkg::BIT_HOST1_STOPPABLE] && !host_clock_stop_n_in);
      running_r[2] <= out_en[clock_gen_pkg::BIT_HOST2_EN] &&
                      !(ref_stop[clock_gen_pkg::BIT_HOST2_STOPPABLE] && !host_clock_stop_n_in);
    end
  end

  // sda only ever pulls low; the level is fixed so the enable carries the data
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      sda_out <= 1'b0;
    else
      sda_out <= 1'b0;
  end

  assign sda_oe_n_out = oe_n_r;
  assign host_out_running_out = running_r;
  assign loop_one_enable_out = loop_div[clock_gen_pkg::BIT_LOOP_ONE_EN];
  assign loop_two_enable_out = loop_div[clock_gen_pkg::BIT_LOOP_TWO_EN];
  assign loop_three_enable_out = loop_div[clock_gen_pkg::BIT_LOOP_THREE_EN];
  assign host_divider_enable_out = loop_div[clock_gen_pkg::BIT_HOST_DIV_EN];
  assign link_divider_enable_out = loop_div[clock_gen_pkg::BIT_LINK_DIV_EN];
  assign panel_divider_enable_out = loop_div[clock_gen_pkg::BIT_PANEL_DIV_EN];
  assign display96_divider_enable_out = loop_div[clock_gen_pkg::BIT_DISPLAY96_DIV_EN];
  assign loop_one_spread_enable_out = spread[clock_gen_pkg::BIT_LOOP_ONE_SPREAD];
  assign loop_three_spread_enable_out = spread[clock_gen_pkg::BIT_LOOP_THREE_SPREAD];
  assign loop_three_spread_profile_out = spread[clock_gen_pkg::BIT_PROFILE_HI:clock_gen_pkg::BIT_PROFILE_LO];
  assign host_out0_enable_out = out_en[clock_gen_pkg::BIT_HOST0_EN];
  assign host_out1_enable_out = out_en[clock_gen_pkg::BIT_HOST1_EN];
  assign host_out2_enable_out = out_en[clock_gen_pkg::BIT_HOST2_EN];
  assign link_out0_enable_out = out_en[clock_gen_pkg::BIT_LINK0_EN];
  assign link_out1_enable_out = out_en[clock_gen_pkg::BIT_LINK1_EN];
  assign link_out2_enable_out = out_en[clock_gen_pkg::BIT_LINK2_EN];
  assign display_96m_clock_enable_out = out_en[clock_gen_pkg::BIT_DISPLAY96_EN];
  assign panel_video_clock_enable_out = out_en[clock_gen_pkg::BIT_PANEL_EN];
  assign reference_enable_out = ref_stop[clock_gen_pkg::BIT_REF_EN];
  assign reference_slew_select_out = ref_stop[clock_gen_pkg::BIT_REF_SLEW];
  assign host_out0_stoppable_out = ref_stop[clock_gen_pkg::BIT_HOST0_STOPPABLE];
  assign host_out1_stoppable_out = ref_stop[clock_gen_pkg::BIT_HOST1_STOPPABLE];
  assign host_out2_stoppable_out = ref_stop[clock_gen_pkg::BIT_HOST2_STOPPABLE];

endmodule

// ==== src/clock_gen_pkg.sv ====
// constants shared by the clock generator control register bank
// assumes a single 20 MHz clock domain and a two-wire serial slave front end
package clock_gen_pkg;

  // eight-bit slave address byte, write form
  localparam logic [7:0] DEV_ADDR = 8'hd2;
  localparam int CMD_SINGLE_BIT = 7;

  // register byte indices
  localparam logic [6:0] IDX_LOOP_DIV = 7'h00;
  localparam logic [6:0] IDX_SPREAD = 7'h01;
  localparam logic [6:0] IDX_OUT_EN = 7'h02;
  localparam logic [6:0] IDX_REF_STOP = 7'h03;
  localparam logic [6:0] IDX_L1_M = 7'h04;
  localparam logic [6:0] IDX_L1_N = 7'h05;
  localparam logic [6:0] IDX_L2_MN = 7'h06;

  // byte count returned first in a block read
  localparam logic [7:0] BLOCK_BYTE_COUNT = 8'h07;

  // power-up values, reserved bits included
  localparam logic [7:0] RST_LOOP_DIV = 8'hef;
  localparam logic [7:0] RST_SPREAD = 8'hc0;
  localparam logic [7:0] RST_OUT_EN = 8'hff;
  localparam logic [7:0] RST_REF_STOP = 8'hf0;

  // bits that a write may change
  localparam logic [7:0] WMASK_LOOP_DIV = 8'hef;
  localparam logic [7:0] WMASK_SPREAD = 8'hf8;
  localparam logic [7:0] WMASK_OUT_EN = 8'hff;
  localparam logic [7:0] WMASK_REF_STOP = 8'h37;

  // field positions
  localparam int BIT_LOOP_ONE_EN = 7;
  localparam int BIT_LOOP_TWO_EN = 6;
  localparam int BIT_LOOP_THREE_EN = 5;
  localparam int BIT_HOST_DIV_EN = 3;
  localparam int BIT_LINK_DIV_EN = 2;
  localparam int BIT_PANEL_DIV_EN = 1;
  localparam int BIT_DISPLAY96_DIV_EN = 0;
  localparam int BIT_LOOP_ONE_SPREAD = 7;
  localparam int BIT_LOOP_THREE_SPREAD = 6;
  localparam int BIT_PROFILE_HI = 5;
  localparam int BIT_PROFILE_LO = 3;
  localparam int BIT_HOST0_EN = 7;
  localparam int BIT_HOST1_EN = 6;
  localparam int BIT_HOST2_EN = 5;
  localparam int BIT_LINK0_EN = 4;
  localparam int BIT_LINK1_EN = 3;
  localparam int BIT_LINK2_EN = 2;
  localparam int BIT_DISPLAY96_EN = 1;
  localparam int BIT_PANEL_EN = 0;
  localparam int BIT_REF_EN = 5;
  localparam int BIT_REF_SLEW = 4;
  localparam int BIT_HOST0_STOPPABLE = 2;
  localparam int BIT_HOST1_STOPPABLE = 1;
  localparam int BIT_HOST2_STOPPABLE = 0;

  // kind of byte being received
  localparam logic [1:0] KIND_ADDR = 2'h0;
  localparam logic [1:0] KIND_CMD = 2'h1;
  localparam logic [1:0] KIND_COUNT = 2'h2;
  localparam logic [1:0] KIND_DATA = 2'h3;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b0_0001,
    ST_RX = 5'b0_0010,
    ST_ACK = 5'b0_0100,
    ST_TX = 5'b0_1000,
    ST_RACK = 5'b1_0000
  } link_state_t;

endpackage

// ==== src/ctrl_byte_file.sv ====
// register bytes 0 to 6: four writable control bytes and three hardware bytes
// assumes write strobes and indices come from the serial slave in the same clock domain
`timescale 1ns/100ps
module ctrl_byte_file (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic wr_en_in,
  input wire logic [6:0] idx_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [7:0] loop_one_m_value_in,
  input wire logic [7:0] loop_one_n_value_in,
  input wire logic [5:0] loop_two_m_value_in,
  input wire logic [1:0] loop_two_n_value_in,
  output logic [7:0] rd_data_out,
  output logic [7:0] loop_div_out,
  output logic [7:0] spread_out,
  output logic [7:0] out_en_out,
  output logic [7:0] ref_stop_out
);

  logic [7:0] loop_div_r;
  logic [7:0] spread_r;
  logic [7:0] out_en_r;
  logic [7:0] ref_stop_r;

  // reserved bits keep their power-up value whatever is written
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] data, input logic [7:0] mask);
    merge = (old & ~mask) | (data & mask);
  endfunction

  wire hit_loop_div = wr_en_in && (idx_in == clock_gen_pkg::IDX_LOOP_DIV);
  wire hit_spread = wr_en_in && (idx_in == clock_gen_pkg::IDX_SPREAD);
  wire hit_out_en = wr_en_in && (idx_in == clock_gen_pkg::IDX_OUT_EN);
  wire hit_ref_stop = wr_en_in && (idx_in == clock_gen_pkg::IDX_REF_STOP);

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      loop_div_r <= clock_gen_pkg::RST_LOOP_DIV;
      spread_r <= clock_gen_pkg::RST_SPREAD;
      out_en_r <= clock_gen_pkg::RST_OUT_EN;
      ref_stop_r <= clock_gen_pkg::RST_REF_STOP;
    end
    else
    begin
      if (hit_loop_div)
        loop_div_r <= merge(loop_div_r, wr_data_in, clock_gen_pkg::WMASK_LOOP_DIV);
      if (hit_spread)
        spread_r <= merge(spread_r, wr_data_in, clock_gen_pkg::WMASK_SPREAD);
      if (hit_out_en)
        out_en_r <= merge(out_en_r, wr_data_in, clock_gen_pkg::WMASK_OUT_EN);
      if (hit_ref_stop)
        ref_stop_r <= merge(ref_stop_r, wr_data_in, clock_gen_pkg::WMASK_REF_STOP);
    end
  end

  // bytes past the covered range read as zero
  always_comb
  begin
    unique case (idx_in)
      clock_gen_pkg::IDX_LOOP_DIV: rd_data_out = loop_div_r;
      clock_gen_pkg::IDX_SPREAD: rd_data_out = spread_r;
      clock_gen_pkg::IDX_OUT_EN: rd_data_out = out_en_r;
      clock_gen_pkg::IDX_REF_STOP: rd_data_out = ref_stop_r;
      clock_gen_pkg::IDX_L1_M: rd_data_out = loop_one_m_value_in;
      clock_gen_pkg::IDX_L1_N: rd_data_out = loop_one_n_value_in;
      clock_gen_pkg::IDX_L2_MN: rd_data_out = {loop_two_n_value_in[0], loop_two_n_value_in[1],
                                               loop_two_m_value_in};
      default: rd_data_out = 8'h00;
    endcase
  end

  assign loop_div_out = loop_div_r;
  assign spread_out = spread_r;
  assign out_en_out = out_en_r;
  assign ref_stop_out = ref_stop_r;

endmodule

// ==== tb/clock_gen_control_regs_assertions.sv ====
// pin assertions for the clock generator register bank
// assumes it is bound into clock_gen_control_regs, one clock domain
`timescale 1ns/100ps
module clock_gen_control_regs_assertions (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe_n_out,
  input wire logic host_clock_stop_n_in,
  input wire logic loop_one_enable_out,
  input wire logic loop_two_enable_out,
  input wire logic loop_three_enable_out,
  input wire logic [2:0] loop_three_spread_profile_out,
  input wire logic host_out0_enable_out,
  input wire logic host_out1_enable_out,
  input wire logic host_out2_enable_out,
  input wire logic host_out0_stoppable_out,
  input wire logic host_out1_stoppable_out,
  input wire logic host_out2_stoppable_out,
  input wire logic [2:0] host_out_running_out
);
  wire logic [11:0] sub_w;
  wire logic [2:0] run_w;
  assign sub_w = {loop_one_enable_out, loop_two_enable_out, loop_three_enable_out, loop_three_spread_profile_out,
    host_out0_enable_out, host_out1_enable_out, host_out2_enable_out, host_out0_stoppable_out,
    host_out1_stoppable_out, host_out2_stoppable_out};
  // stop input is active low; a stoppable output halts only while it is low
  assign run_w = {host_out2_enable_out & ~(host_out2_stoppable_out & ~host_clock_stop_n_in),
    host_out1_enable_out & ~(host_out1_stoppable_out & ~host_clock_stop_n_in),
    host_out0_enable_out & ~(host_out0_stoppable_out & ~host_clock_stop_n_in)};
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  sequence start_seen;
    scl_in && $past(scl_in) && $fell(sda_in);
  endsequence
  sequence stop_seen;
    scl_in && $past(scl_in) && $rose(sda_in);
  endsequence
  // the pin compare adds a cycle, so the drive lands two or three samples after the fall
  sequence after_fall;
    !scl_in && ($past(scl_in, 2) || $past(scl_in, 3));
  endsequence
  reset_values_a: assert property ($rose(resetn_in) |-> sub_w == 12'he38 && host_out_running_out == 3'h7)
    else $error("outputs not at power-up values");
  data_change_a: assert property ($changed(sda_oe_n_out) |-> !scl_in)
    else $error("data drive changed while clock high");
  drive_launch_a: assert property ($fell(sda_oe_n_out) |-> after_fall)
    else $error("data drive not launched after clock fall");
  drive_bound_a: assert property ($fell(sda_oe_n_out) |-> ##[1:300] $rose(sda_oe_n_out))
    else $error("data line held too long");
  high_stable_a: assert property ($rose(scl_in) |=> $stable(sda_oe_n_out) [*3])
    else $error("data drive moved in clock high phase");
  config_quiet_a: assert property (!$stable(sub_w) |-> !scl_in)
    else $error("control bits moved outside a bus write");
  start_free_a: assert property (start_seen |-> sda_oe_n_out)
    else $error("line driven at start");
  stop_free_a: assert property (stop_seen |-> sda_oe_n_out [*4])
    else $error("line driven after stop");
  host_run_a: assert property ($past(resetn_in) |-> host_out_running_out == $past(run_w))
    else $error("host running state wrong");
endmodule
bind clock_gen_control_regs clock_gen_control_regs_assertions i_chk (.*);

// ==== tb/serial_host_model.sv ====
// behavioural two-wire host controller for the register bank
// assumes the bench resolves the open-drain data wire and feeds it back
`timescale 1ns/100ps
module serial_host_model (
  input wire logic clk_in,
  input wire logic sda_line_in,
  output logic scl_out,
  output logic sda_drive_out,
  output logic [7:0] rx_byte_out,
  output logic rx_stb_out
);
  // extra low-phase cycles; a slow host stretches every bit
  int low_extra = 0;
  initial
  begin
    scl_out = 1'b1;
    sda_drive_out = 1'b1;
    rx_byte_out = 8'h00;
    rx_stb_out = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // data changes mid-low and is sampled late in the high phase, where it has settled
  task automatic clock_bit(input logic b, output logic s);
    scl_out <= 1'b0;
    wait_clk(2);
    sda_drive_out <= b;
    wait_clk(3 + low_extra);
    scl_out <= 1'b1;
    wait_clk(4);
    s = sda_line_in;
  endtask
  task automatic start_cond();
    logic s;
    clock_bit(1'b1, s);
    sda_drive_out <= 1'b0;
    wait_clk(4);
  endtask
  task automatic stop_cond();
    logic s;
    clock_bit(1'b0, s);
    sda_drive_out <= 1'b1;
    wait_clk(4);
  endtask
  task automatic byte_io(input logic [7:0] tx, input logic mack, input logic rd, output logic [7:0] rx,
    output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      clock_bit(tx[i], s);
      rx[i] = s;
    end
    clock_bit(mack, s);
    ack = !s;
    if (rd)
    begin
      rx_byte_out <= rx;
      rx_stb_out <= 1'b1;
      wait_clk(1);
      rx_stb_out <= 1'b0;
    end
  endtask
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench for the clock generator register bank
// assumes serial_host_model on the two-wire side and the bound checker
`timescale 1ns/100ps
`define CHECK(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      num_errors++; \
      $display("FAIL %0t got %h exp %h", $time, g, e); \
    end \
  end
module tb_top;
  logic clk_in;
  logic resetn_in;
  logic stop_n;
  logic [7:0] m1;
  logic [7:0] n1;
  logic [5:0] m2;
  logic [1:0] n2;
  wire logic scl;
  wire logic host_sda;
  wire logic sda_out;
  wire logic sda_oe_n;
  wire logic rx_stb;
  wire logic [7:0] rx_byte;
  wire logic [2:0] running;
  wire logic [24:0] cfg_w;
  wire logic sda_line;
  logic [7:0] mirror [0:6];
  logic [7:0] notes [$];
  logic [7:0] note_v;
  int num_errors = 0;
  int tests_run = 0;
  // open drain with pull-up: low if either party pulls
  assign sda_line = host_sda & (sda_oe_n | sda_out);
  serial_host_model i_host (.clk_in(clk_in), .sda_line_in(sda_line), .scl_out(scl), .sda_drive_out(host_sda),
    .rx_byte_out(rx_byte), .rx_stb_out(rx_stb));
  clock_gen_control_regs i_dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_n_out(sda_oe_n), .host_clock_stop_n_in(stop_n), .loop_one_m_value_in(m1),
    .loop_one_n_value_in(n1), .loop_two_m_value_in(m2), .loop_two_n_value_in(n2),
    .loop_one_enable_out(cfg_w[24]), .loop_two_enable_out(cfg_w[23]), .loop_three_enable_out(cfg_w[22]),
    .host_divider_enable_out(cfg_w[21]), .link_divider_enable_out(cfg_w[20]),
    .panel_divider_enable_out(cfg_w[19]), .display96_divider_enable_out(cfg_w[18]),
    .loop_one_spread_enable_out(cfg_w[17]), .loop_three_spread_enable_out(cfg_w[16]),
    .loop_three_spread_profile_out(cfg_w[15:13]), .host_out0_enable_out(cfg_w[12]),
    .host_out1_enable_out(cfg_w[11]), .host_out2_enable_out(cfg_w[10]), .link_out0_enable_out(cfg_w[9]),
    .link_out1_enable_out(cfg_w[8]), .link_out2_enable_out(cfg_w[7]), .display_96m_clock_enable_out(cfg_w[6]),
    .panel_video_clock_enable_out(cfg_w[5]), .reference_enable_out(cfg_w[4]),
    .reference_slew_select_out(cfg_w[3]), .host_out0_stoppable_out(cfg_w[2]),
    .host_out1_stoppable_out(cfg_w[1]), .host_out2_stoppable_out(cfg_w[0]), .host_out_running_out(running));
  function automatic logic [2:0] run_exp();
    logic [2:0] r;
    for (int i = 0; i < 3; i++)
      r[i] = mirror[2][7 - i] & !(mirror[3][2 - i] & !stop_n);
    return r;
  endfunction
  task automatic complete_run();
    if (num_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic reset_cycle();
    resetn_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'b1;
    mirror = '{clock_gen_pkg::RST_LOOP_DIV, clock_gen_pkg::RST_SPREAD, clock_gen_pkg::RST_OUT_EN,
      clock_gen_pkg::RST_REF_STOP, m1, n1, {n2[0], n2[1], m2}};
    repeat (2) @(posedge clk_in);
  endtask
  task automatic check_cfg();
    repeat (3) @(posedge clk_in);
    `CHECK(cfg_w, {mirror[0][7:5], mirror[0][3:0], mirror[1][7:3], mirror[2], mirror[3][5:4], mirror[3][2:0]})
    `CHECK(running, run_exp())
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ack_exp);
    logic [7:0] rx;
    logic a;
    i_host.byte_io(tx, 1'b1, 1'b0, rx, a);
    `CHECK(a, ack_exp)
  endtask
  task automatic head(input logic [7:0] cmd);
    i_host.start_cond();
    xfer(clock_gen_pkg::DEV_ADDR, 1'b1);
    xfer(cmd, 1'b1);
  endtask
  // reserved and hardware bits are masked out of the expected image
  task automatic put(input int i, input logic [7:0] v);
    logic [7:0] wm [0:3] = '{clock_gen_pkg::WMASK_LOOP_DIV, clock_gen_pkg::WMASK_SPREAD,
      clock_gen_pkg::WMASK_OUT_EN, clock_gen_pkg::WMASK_REF_STOP};
    xfer(v, 1'b1);
    if (i < 4)
      mirror[i] = (mirror[i] & ~wm[i]) | (v & wm[i]);
  endtask
  task automatic wr(input logic [6:0] idx, input logic [7:0] v);
    head({1'b1, idx});
    put(int'(idx), v);
    i_host.stop_cond();
  endtask
  task automatic rd(input logic [7:0] cmd, input int n);
    logic [7:0] rx;
    logic a;
    int idx;
    idx = cmd[7] ? int'(cmd[6:0]) : -1;
    head(cmd);
    i_host.start_cond();
    xfer(clock_gen_pkg::DEV_ADDR | 8'h01, 1'b1);
    for (int k = 0; k < n; k++)
    begin
      notes.push_back(idx < 0 ? clock_gen_pkg::BLOCK_BYTE_COUNT : (idx < 7 ? mirror[idx] : 8'h00));
      idx++;
      i_host.byte_io(8'hff, k == n - 1, 1'b1, rx, a);
    end
    i_host.stop_cond();
  endtask
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
    if (rx_stb === 1'b1)
    begin
      // pop once: the compare macro evaluates its expected value twice on a mismatch
      note_v = notes.pop_front();
      `CHECK(rx_byte, note_v)
    end
  initial
  begin
    repeat (90000) @(posedge clk_in);
    num_errors++;
    complete_run();
  end
  initial
  begin
    resetn_in = 1'b0;
    stop_n = 1'b1;
    {m1, n1, m2, n2} = 24'h00_0000;
    void'($urandom(32'h2117));
    @(posedge clk_in);
    {m1, n1, m2, n2} <= 24'($urandom());
    reset_cycle();
    check_cfg();
    rd(8'h00, 8);
    for (int r = 0; r < 8; r++)
    begin
      stop_n <= r[0];
      wr(7'h00, 8'($urandom()));
      wr(7'h01, {2'($urandom()), r[2:0], 3'($urandom())});
      wr(7'h02, 8'($urandom()));
      wr(7'h03, 8'($urandom()));
      check_cfg();
      rd(8'h80, 7);
    end
    // hardware bytes and unmapped indices ignore writes
    wr(7'h04, 8'($urandom()));
    wr(7'h09, 8'hff);
    rd(8'h84, 1);
    rd(8'h89, 1);
    // slow host, block write cut short after three bytes
    i_host.low_extra = 6;
    head(8'h00);
    xfer(8'h03, 1'b1);
    for (int k = 0; k < 3; k++)
      put(k, 8'($urandom()));
    i_host.stop_cond();
    rd(8'h00, 5);
    check_cfg();
    i_host.start_cond();
    xfer(8'hd4, 1'b0);
    i_host.stop_cond();
    i_host.low_extra = 0;
    check_cfg();
    {m1, n1, m2, n2} <= 24'($urandom());
    reset_cycle();
    check_cfg();
    rd(8'h00, 8);
    repeat (20) @(posedge clk_in);
    complete_run();
  end
endmodule
